//--- include/lesr_regs.svh
`ifndef LESR_REGS_SVH
`define LESR_REGS_SVH

// Register offsets
`define LESR_EQ_STATE_READBACK_ADDR 8'h3B
`define LESR_SERIAL_FAULT_CTL_ADDR 8'h41
`define LESR_FAST_SIDE_CHAN_ADDR 8'h43
`define LESR_EQ_MANUAL_ADDR 8'h44
`define LESR_EQ_START_LEVEL_ADDR 8'h45
`define LESR_LOOP_SOURCE_ADDR 8'h52

// Reset values
`define LESR_SERIAL_FAULT_CTL_RST 8'h03
`define LESR_FAST_SIDE_CHAN_RST 8'h00
`define LESR_EQ_MANUAL_RST 8'h60
`define LESR_EQ_START_LEVEL_RST 8'h88
`define LESR_LOOP_SOURCE_RST 8'h00

// Field positions
`define LESR_FAULT_ENABLE_BIT 4
`define LESR_FAULT_THRESH_MSB 3
`define LESR_FAULT_THRESH_LSB 0
`define LESR_MISO_MODE_BIT 4
`define LESR_CPOL_BIT 3
`define LESR_MODE_MSB 2
`define LESR_MODE_LSB 0
`define LESR_EQ_UPPER_MSB 7
`define LESR_EQ_UPPER_LSB 5
`define LESR_EQ_LOWER_MSB 3
`define LESR_EQ_LOWER_LSB 1
`define LESR_EQ_ADAPT_OFF_BIT 0
`define LESR_FLOOR_MSB 3
`define LESR_FLOOR_LSB 0
`define LESR_LOOP_SOURCE_BIT 7
`define LESR_EQ_VALUE_MSB 5

`endif

//--- include/lesr_pkg.sv
package lesr_pkg;

   typedef logic [7:0] lesr_byte_t;
   typedef logic [5:0] lesr_eq_t;
   typedef logic [3:0] lesr_nib_t;

   typedef enum logic [2:0] {
      LESR_MODE_GPIO_NORMAL = 3'h0,
      LESR_MODE_GPIO_HS1 = 3'h1,
      LESR_MODE_GPIO_HS2 = 3'h2,
      LESR_MODE_GPIO_HS4 = 3'h3,
      LESR_MODE_SPI_FWD_NORMAL = 3'h4,
      LESR_MODE_SPI_REV_NORMAL = 3'h5,
      LESR_MODE_SPI_FWD_HS = 3'h6,
      LESR_MODE_SPI_REV_HS = 3'h7
   } lesr_mode_t;

   typedef enum {
      LESR_GUARD_UNLOCKED,
      LESR_GUARD_LOCKED
   } lesr_guard_state_t;

endpackage

//--- rtl/lesr_err_guard.sv
`timescale 1ns/1ps
`include "lesr_regs.svh"

module lesr_err_guard
   import lesr_pkg::*;
#(
   parameter int CNT_W = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Control
   input wire logic count_enable,
   input wire logic [CNT_W-1:0] threshold,
   // Link monitors
   input wire logic link_locked,
   input wire logic clk0_error,
   input wire logic clk1_error,
   input wire logic data_lane_monitor_error,
   // Result
   output logic lock_drop,
   output logic [CNT_W-1:0] fault_count
);
   import lesr_pkg::*;

   lesr_guard_state_t state_q;
   logic [CNT_W-1:0] count_q;
   logic any_error;
   logic reached;

   // Any of the three monitored channels flags one error per cycle
   assign any_error = clk0_error | clk1_error | data_lane_monitor_error; // RULE2
   assign reached = (CNT_W'(count_q + 1'b1) >= threshold) || (count_q == '1);
   // Drop lock at threshold when counting, else on the first error
   assign lock_drop = (state_q == LESR_GUARD_LOCKED) && any_error
      && (!count_enable || reached); // RULE2 RULE3
   assign fault_count = count_q;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_q <= LESR_GUARD_UNLOCKED;
      end else begin
         unique case (state_q)
            LESR_GUARD_UNLOCKED: begin
               if (link_locked) begin
                  state_q <= LESR_GUARD_LOCKED;
               end
            end
            LESR_GUARD_LOCKED: begin
               if (lock_drop || !link_locked) begin
                  state_q <= LESR_GUARD_UNLOCKED;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         count_q <= '0;
      end else if (!count_enable || state_q != LESR_GUARD_LOCKED || lock_drop) begin
         count_q <= '0; // RULE17
      end else if (any_error) begin
         count_q <= CNT_W'(count_q + 1'b1); // RULE1 RULE2
      end
   end

endmodule

//--- rtl/lesr_link_eq_sidechannel_regs.sv
// Behaviour
// RULE1 - Bit 4 enables link error counting
// RULE2 - Count errors on three channels, threshold drop
// RULE3 - Counting off: first error drops lock
// RULE4 - Reverse SPI output tristated unless selected
// RULE5 - Polarity bit picks SPI drive/sample edges
// RULE6 - Mode codes 000-011 select GPIO modes
// RULE7 - Mode codes 100-111 select SPI modes
// RULE8 - Bypass applies fixed six-bit manual setting
// RULE9 - Adaptation starts from programmable floor, reset 8
// RULE10 - Port-1 select retargets floor register writes
// RULE11 - Source bit picks primary or secondary input
// RULE12 - Software enables loop driver before output appears
// RULE13 - Software keeps source bit matching companion field
// RULE14 - Status shows six-bit current equalizer value
// RULE15 - Floor used only with override and apply
// RULE16 - Port select steers register writes and reads
// RULE17 - Error counter clears when off or relocking
`timescale 1ns/1ps
`include "lesr_regs.svh"

module lesr_link_eq_sidechannel_regs
   import lesr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register access port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire lesr_pkg::lesr_byte_t reg_addr,
   input wire lesr_pkg::lesr_byte_t reg_wdata,
   output lesr_pkg::lesr_byte_t reg_rdata,
   output logic reg_rvalid,
   // Port selection and neighbouring control bits
   input wire logic port0_sel,
   input wire logic second_port_access,
   input wire logic eq_floor_override,
   input wire logic eq_floor_apply,
   input wire logic loop_driver_enable,
   // Link error monitoring
   input wire logic link_locked,
   input wire logic clk0_error,
   input wire logic clk1_error,
   input wire logic data_lane_monitor_error,
   output logic lock_drop,
   // Adaptive equalizer, one lane per input port
   input wire lesr_pkg::lesr_eq_t equalizer_current_value_p0,
   input wire lesr_pkg::lesr_eq_t equalizer_current_value_p1,
   output lesr_pkg::lesr_eq_t eq_setting_p0,
   output lesr_pkg::lesr_eq_t eq_setting_p1,
   output logic eq_adapt_off_p0,
   output logic eq_adapt_off_p1,
   output lesr_pkg::lesr_nib_t eq_start_floor_p0,
   output lesr_pkg::lesr_nib_t eq_start_floor_p1,
   output logic eq_floor_active,
   // Side channel
   output lesr_pkg::lesr_mode_t side_channel_mode,
   output logic side_channel_spi,
   output logic side_channel_reverse,
   output logic side_channel_high_speed,
   output logic [2:0] side_channel_gpio_count,
   output logic serial_clock_polarity,
   // SPI pins
   input wire logic spi_sclk_pin,
   input wire logic spi_sel_n_pin,
   input wire logic spi_miso_data,
   output logic spi_miso_out,
   output logic spi_miso_oe_n,
   output logic spi_drive_edge,
   output logic spi_sample_edge,
   // Loop-through
   input wire logic primary_input,
   input wire logic secondary_input,
   output logic loop_through_out
);
   import lesr_pkg::*;

   lesr_byte_t fault_ctl_q;
   lesr_byte_t side_chan_q;
   lesr_byte_t loop_src_q;
   lesr_byte_t eq_manual_q [2];
   lesr_byte_t eq_level_q [2];
   logic [1:0] wr_port;
   logic rd_port;
   logic [1:0] sclk_sync_q;
   logic [1:0] sel_n_sync_q;
   logic sclk_prev_q;
   logic sclk_rise;
   logic sclk_fall;
   logic miso_tristate;
   lesr_byte_t rd_mux;

   function automatic lesr_eq_t manual_value(input lesr_byte_t r);
      manual_value = {r[`LESR_EQ_UPPER_MSB:`LESR_EQ_UPPER_LSB],
                      r[`LESR_EQ_LOWER_MSB:`LESR_EQ_LOWER_LSB]}; // RULE8
   endfunction

   function automatic lesr_eq_t eq_applied(input lesr_byte_t r, input lesr_eq_t adaptive);
      eq_applied = r[`LESR_EQ_ADAPT_OFF_BIT] ? manual_value(r) : adaptive; // RULE8
   endfunction

   // Port steering: writes hit every selected port, reads prefer port 1
   assign wr_port = {second_port_access, port0_sel}; // RULE16 RULE10
   assign rd_port = second_port_access; // RULE16

   // Shared registers
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         fault_ctl_q <= `LESR_SERIAL_FAULT_CTL_RST;
         side_chan_q <= `LESR_FAST_SIDE_CHAN_RST;
         loop_src_q <= `LESR_LOOP_SOURCE_RST;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `LESR_SERIAL_FAULT_CTL_ADDR: fault_ctl_q <= reg_wdata; // RULE1
            `LESR_FAST_SIDE_CHAN_ADDR: side_chan_q <= reg_wdata;
            `LESR_LOOP_SOURCE_ADDR: loop_src_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Per-port equalizer registers
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         for (int p = 0; p < 2; p++) begin
            eq_manual_q[p] <= `LESR_EQ_MANUAL_RST;
            eq_level_q[p] <= `LESR_EQ_START_LEVEL_RST; // RULE9
         end
      end else if (reg_wr) begin
         for (int p = 0; p < 2; p++) begin
            if (wr_port[p] && reg_addr == `LESR_EQ_MANUAL_ADDR) begin
               eq_manual_q[p] <= reg_wdata;
            end
            if (wr_port[p] && reg_addr == `LESR_EQ_START_LEVEL_ADDR) begin
               eq_level_q[p] <= reg_wdata; // RULE10
            end
         end
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         `LESR_EQ_STATE_READBACK_ADDR: begin
            rd_mux = {2'h0, rd_port ? equalizer_current_value_p1 : equalizer_current_value_p0}; // RULE14
         end
         `LESR_SERIAL_FAULT_CTL_ADDR: rd_mux = fault_ctl_q;
         `LESR_FAST_SIDE_CHAN_ADDR: rd_mux = side_chan_q;
         `LESR_EQ_MANUAL_ADDR: rd_mux = eq_manual_q[rd_port]; // RULE16
         `LESR_EQ_START_LEVEL_ADDR: rd_mux = eq_level_q[rd_port]; // RULE16
         `LESR_LOOP_SOURCE_ADDR: rd_mux = loop_src_q;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_mux;
         end
      end
   end

   // Link error guard
   lesr_err_guard #(
      .CNT_W(4)
   ) u_err_guard (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .count_enable(fault_ctl_q[`LESR_FAULT_ENABLE_BIT]), // RULE1
      .threshold(fault_ctl_q[`LESR_FAULT_THRESH_MSB:`LESR_FAULT_THRESH_LSB]), // RULE2
      .link_locked(link_locked),
      .clk0_error(clk0_error),
      .clk1_error(clk1_error),
      .data_lane_monitor_error(data_lane_monitor_error),
      .lock_drop(lock_drop),
      .fault_count()
   );

   // Equalizer controls
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         eq_setting_p0 <= '0;
         eq_setting_p1 <= '0;
         eq_adapt_off_p0 <= 1'b0;
         eq_adapt_off_p1 <= 1'b0;
         eq_start_floor_p0 <= '0;
         eq_start_floor_p1 <= '0;
         eq_floor_active <= 1'b0;
      end else begin
         eq_setting_p0 <= eq_applied(eq_manual_q[0], equalizer_current_value_p0); // RULE8
         eq_setting_p1 <= eq_applied(eq_manual_q[1], equalizer_current_value_p1); // RULE8
         eq_adapt_off_p0 <= eq_manual_q[0][`LESR_EQ_ADAPT_OFF_BIT];
         eq_adapt_off_p1 <= eq_manual_q[1][`LESR_EQ_ADAPT_OFF_BIT];
         eq_start_floor_p0 <= eq_level_q[0][`LESR_FLOOR_MSB:`LESR_FLOOR_LSB]; // RULE9
         eq_start_floor_p1 <= eq_level_q[1][`LESR_FLOOR_MSB:`LESR_FLOOR_LSB]; // RULE9
         eq_floor_active <= eq_floor_override & eq_floor_apply; // RULE15
      end
   end

   // Side channel mode decode
   assign side_channel_mode = lesr_mode_t'(side_chan_q[`LESR_MODE_MSB:`LESR_MODE_LSB]);
   assign serial_clock_polarity = side_chan_q[`LESR_CPOL_BIT];

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         side_channel_spi <= 1'b0;
         side_channel_reverse <= 1'b0;
         side_channel_high_speed <= 1'b0;
         side_channel_gpio_count <= 3'h0;
      end else begin
         side_channel_spi <= 1'b0;
         side_channel_reverse <= 1'b0;
         side_channel_high_speed <= 1'b0;
         side_channel_gpio_count <= 3'h0;
         unique case (side_channel_mode)
            LESR_MODE_GPIO_NORMAL: side_channel_gpio_count <= 3'h0; // RULE6
            LESR_MODE_GPIO_HS1: begin
               side_channel_high_speed <= 1'b1;
               side_channel_gpio_count <= 3'h1; // RULE6
            end
            LESR_MODE_GPIO_HS2: begin
               side_channel_high_speed <= 1'b1;
               side_channel_gpio_count <= 3'h2; // RULE6
            end
            LESR_MODE_GPIO_HS4: begin
               side_channel_high_speed <= 1'b1;
               side_channel_gpio_count <= 3'h4; // RULE6
            end
            LESR_MODE_SPI_FWD_NORMAL: side_channel_spi <= 1'b1; // RULE7
            LESR_MODE_SPI_REV_NORMAL: begin
               side_channel_spi <= 1'b1;
               side_channel_reverse <= 1'b1; // RULE7
            end
            LESR_MODE_SPI_FWD_HS: begin
               side_channel_spi <= 1'b1;
               side_channel_high_speed <= 1'b1; // RULE7
            end
            LESR_MODE_SPI_REV_HS: begin
               side_channel_spi <= 1'b1;
               side_channel_reverse <= 1'b1;
               side_channel_high_speed <= 1'b1; // RULE7
            end
         endcase
      end
   end

   // SPI pin synchronisers
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sclk_sync_q <= 2'h0;
         sel_n_sync_q <= 2'h3;
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_sync_q <= {sclk_sync_q[0], spi_sclk_pin};
         sel_n_sync_q <= {sel_n_sync_q[0], spi_sel_n_pin};
         sclk_prev_q <= sclk_sync_q[1];
      end
   end

   assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
   assign sclk_fall = ~sclk_sync_q[1] & sclk_prev_q;
   // Polarity 0: drive on fall, sample on rise; 1 the reverse
   assign spi_drive_edge = serial_clock_polarity ? sclk_rise : sclk_fall; // RULE5
   assign spi_sample_edge = serial_clock_polarity ? sclk_fall : sclk_rise; // RULE5

   assign miso_tristate = side_chan_q[`LESR_MISO_MODE_BIT] & sel_n_sync_q[1]; // RULE4

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         spi_miso_out <= 1'b0;
         spi_miso_oe_n <= 1'b1;
      end else begin
         if (side_channel_spi && side_channel_reverse && spi_drive_edge) begin
            spi_miso_out <= spi_miso_data; // RULE5
         end
         spi_miso_oe_n <= ~(side_channel_spi && side_channel_reverse && !miso_tristate); // RULE4
      end
   end

   // Loop-through source, gated by the driver enable
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         loop_through_out <= 1'b0;
      end else if (loop_driver_enable) begin // RULE12
         loop_through_out <= loop_src_q[`LESR_LOOP_SOURCE_BIT] ? secondary_input : primary_input; // RULE11
      end else begin
         loop_through_out <= 1'b0;
      end
   end

endmodule

//--- testbench/lesr_assertions.sv
`timescale 1ns/1ps
module lesr_assertions
   import lesr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register port
   input wire logic reg_rd,
   input wire lesr_pkg::lesr_byte_t reg_rdata,
   input wire logic reg_rvalid,
   // Controls and decoded outputs
   input wire logic eq_floor_override,
   input wire logic eq_floor_apply,
   input wire logic eq_floor_active,
   input wire logic loop_driver_enable,
   input wire logic loop_through_out,
   input wire lesr_pkg::lesr_mode_t side_channel_mode,
   input wire logic side_channel_spi,
   input wire logic side_channel_reverse,
   input wire logic spi_miso_oe_n,
   // Link monitoring
   input wire logic link_locked,
   input wire logic clk0_error,
   input wire logic clk1_error,
   input wire logic data_lane_monitor_error,
   input wire logic lock_drop
);
   import lesr_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_read_answer: assert property ($past(reset_n) |-> reg_rvalid == $past(reg_rd))
      else $error("read answer not one cycle after strobe");
   a_rdata_hold: assert property (!reg_rvalid && $past(reset_n) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_drop_cause: assert property (lock_drop |-> clk0_error || clk1_error || data_lane_monitor_error)
      else $error("lock drop without a link error");
   a_drop_locked: assert property (lock_drop |-> $past(link_locked))
      else $error("lock drop while link unlocked");
   a_floor_gate: assert property ($past(reset_n) |-> eq_floor_active == $past(eq_floor_override && eq_floor_apply))
      else $error("floor active does not follow override and apply");
   a_mode_decode: assert property ($past(reset_n) |-> side_channel_spi == $past(side_channel_mode[2])
      && side_channel_reverse == $past(side_channel_mode[2] && side_channel_mode[0]))
      else $error("side channel decode wrong");
   a_miso_quiet: assert property (!side_channel_reverse && $past(!side_channel_reverse) |-> spi_miso_oe_n)
      else $error("data output driven outside reverse mode");
   a_loop_off: assert property (!loop_driver_enable && $past(!loop_driver_enable) |-> !loop_through_out)
      else $error("loop output active with driver off");

   c_drop: cover property (lock_drop);
   c_read: cover property (reg_rvalid && reg_rdata != 8'h00);
   c_miso: cover property (!spi_miso_oe_n);
endmodule

bind lesr_link_eq_sidechannel_regs lesr_assertions u_chk (.sys_clk, .reset_n, .reg_rd, .reg_rdata, .reg_rvalid,
   .eq_floor_override, .eq_floor_apply, .eq_floor_active, .loop_driver_enable, .loop_through_out,
   .side_channel_mode, .side_channel_spi, .side_channel_reverse, .spi_miso_oe_n, .link_locked,
   .clk0_error, .clk1_error, .data_lane_monitor_error, .lock_drop);

//--- testbench/lesr_remote_link.sv
`timescale 1ns/1ps
module lesr_remote_link (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Error injection per channel
   input wire logic [2:0] err_cmd,
   // Link side
   input wire logic lock_drop,
   output logic link_locked,
   output logic clk0_error,
   output logic clk1_error,
   output logic data_lane_monitor_error,
   output logic primary_input,
   output logic secondary_input
);
   logic [3:0] relock_q;
   logic [1:0] pat_q;

   // Link takes a few cycles to come back after any lock loss
   always_ff @(posedge sys_clk) begin
      if (!reset_n || lock_drop) begin
         relock_q <= 4'h4;
      end else if (relock_q != 4'h0) begin
         relock_q <= relock_q - 4'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pat_q <= 2'h0;
      end else begin
         pat_q <= pat_q + 2'h1;
      end
   end

   // Errors are not gated by lock, as on a real noisy link
   assign link_locked = (relock_q == 4'h0);
   assign clk0_error = err_cmd[0];
   assign clk1_error = err_cmd[1];
   assign data_lane_monitor_error = err_cmd[2];
   assign primary_input = pat_q[1];
   assign secondary_input = ~pat_q[1];
endmodule

//--- testbench/test_link_eq_sidechannel_regs.sv
`timescale 1ns/1ps
module test_link_eq_sidechannel_regs;
   import lesr_pkg::*;
   typedef struct {
      lesr_byte_t addr;
      lesr_byte_t wdata;
      lesr_byte_t rexp;
   } lesr_row_t;
   logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   lesr_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic port0_sel = 1'b1, second_port_access = 1'b0, eq_floor_override = 1'b0, eq_floor_apply = 1'b0;
   logic loop_driver_enable = 1'b0, spi_sclk_pin = 1'b0, spi_sel_n_pin = 1'b1, spi_miso_data = 1'b1;
   logic [2:0] err_cmd = 3'h0, side_channel_gpio_count;
   lesr_eq_t equalizer_current_value_p0 = 6'h2A, equalizer_current_value_p1 = 6'h15, eq_setting_p0, eq_setting_p1;
   lesr_nib_t eq_start_floor_p0, eq_start_floor_p1;
   lesr_mode_t side_channel_mode;
   logic reg_rvalid, link_locked, clk0_error, clk1_error, data_lane_monitor_error, lock_drop, eq_adapt_off_p0;
   logic eq_adapt_off_p1, eq_floor_active, side_channel_spi, side_channel_reverse, side_channel_high_speed;
   logic serial_clock_polarity, spi_miso_out, spi_miso_oe_n, spi_drive_edge, spi_sample_edge;
   logic primary_input, secondary_input, loop_through_out, p;
   int fail_count = 0, checks = 0, cycles = 0, i, d, s;
   lesr_row_t rows[7] = '{'{8'h41, 8'h15, 8'h15}, '{8'h43, 8'h1D, 8'h1D}, '{8'h44, 8'hAF, 8'hAF},
      '{8'h45, 8'h05, 8'h05}, '{8'h52, 8'h80, 8'h80}, '{8'h60, 8'h5A, 8'h00}, '{8'h3B, 8'hFF, 8'h2A}};

   lesr_link_eq_sidechannel_regs uut (.sys_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid, .port0_sel, .second_port_access, .eq_floor_override, .eq_floor_apply, .loop_driver_enable,
      .link_locked, .clk0_error, .clk1_error, .data_lane_monitor_error, .lock_drop, .equalizer_current_value_p0,
      .equalizer_current_value_p1, .eq_setting_p0, .eq_setting_p1, .eq_adapt_off_p0, .eq_adapt_off_p1,
      .eq_start_floor_p0, .eq_start_floor_p1, .eq_floor_active, .side_channel_mode, .side_channel_spi,
      .side_channel_reverse, .side_channel_high_speed, .side_channel_gpio_count, .serial_clock_polarity,
      .spi_sclk_pin, .spi_sel_n_pin, .spi_miso_data, .spi_miso_out, .spi_miso_oe_n, .spi_drive_edge,
      .spi_sample_edge, .primary_input, .secondary_input, .loop_through_out);
   lesr_remote_link u_link (.sys_clk, .reset_n, .err_cmd, .lock_drop, .link_locked, .clk0_error, .clk1_error,
      .data_lane_monitor_error, .primary_input, .secondary_input);

   initial begin
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic end_sim;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Every task but chk and end_sim starts on an edge and ends settled just after one
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wr(input lesr_byte_t a, input lesr_byte_t dat);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= dat;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      cyc(1);
   endtask

   task automatic rd(input lesr_byte_t a, input lesr_byte_t exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rvalid, 1'b1);
      chk(reg_rdata, exp);
   endtask

   task automatic inj(input logic [2:0] ch, input logic exp);
      @(posedge sys_clk);
      err_cmd <= ch;
      #1;
      chk(lock_drop, exp);
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         fail_count++;
         end_sim;
      end
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (i = 0; i < 7; i++) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].rexp);
      end
      @(posedge sys_clk);
      reset_n <= 1'b0;
      cyc(10);
      @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(8'h41, 8'h03);
      rd(8'h43, 8'h00);
      rd(8'h44, 8'h60);
      rd(8'h45, 8'h88);
      rd(8'h52, 8'h00);
      for (i = 0; i < 8; i++) begin
         wr(8'h43, {4'h0, i[0], i[2:0]});
         chk(side_channel_mode, i[2:0]);
         chk(side_channel_spi, i[2]);
         chk(side_channel_reverse, i[2] & i[0]);
         chk(side_channel_high_speed, i[2] ? i[1] : i[1:0] != 2'h0);
         chk(side_channel_gpio_count, i[2] ? 3'h0 : (i[1:0] == 2'h3 ? 3'h4 : {1'b0, i[1:0]}));
         chk(serial_clock_polarity, i[0]);
      end
      for (i = 0; i < 4; i++) begin
         wr(8'h43, {4'h0, i[1], 3'h4});
         @(posedge sys_clk);
         spi_sclk_pin <= ~i[0];
         d = 0;
         s = 0;
         repeat (6) begin
            cyc(1);
            d += spi_drive_edge;
            s += spi_sample_edge;
         end
         chk(d, i[0] ^ i[1]);
         chk(s, !(i[0] ^ i[1]));
      end
      wr(8'h43, 8'h15);
      cyc(6);
      chk(spi_miso_oe_n, 1'b1);
      @(posedge sys_clk);
      spi_sel_n_pin <= 1'b0;
      cyc(6);
      chk(spi_miso_oe_n, 1'b0);
      @(posedge sys_clk);
      spi_sel_n_pin <= 1'b1;
      wr(8'h43, 8'h07);
      cyc(6);
      chk(spi_miso_oe_n, 1'b0);
      // Polarity 0: a rising clock must not launch data, a falling one must
      @(posedge sys_clk);
      spi_sclk_pin <= 1'b1;
      cyc(6);
      chk(spi_miso_out, 1'b0);
      @(posedge sys_clk);
      spi_sclk_pin <= 1'b0;
      cyc(6);
      chk(spi_miso_out, 1'b1);
      wr(8'h41, 8'h13);
      inj(3'h7, 1'b0);
      inj(3'h2, 1'b0);
      inj(3'h4, 1'b1);
      inj(3'h1, 1'b0);
      inj(3'h0, 1'b0);
      cyc(8);
      inj(3'h1, 1'b0);
      inj(3'h1, 1'b0);
      inj(3'h0, 1'b0);
      wr(8'h41, 8'h03);
      wr(8'h41, 8'h13);
      inj(3'h1, 1'b0);
      inj(3'h1, 1'b0);
      inj(3'h1, 1'b1);
      inj(3'h0, 1'b0);
      cyc(8);
      wr(8'h41, 8'h03);
      inj(3'h2, 1'b1);
      inj(3'h0, 1'b0);
      wr(8'h44, 8'hAF);
      chk(eq_adapt_off_p0, 1'b1);
      chk(eq_setting_p0, 6'h2F);
      chk(eq_setting_p1, 6'h15);
      chk(eq_adapt_off_p1, 1'b0);
      @(posedge sys_clk);
      port0_sel <= 1'b0;
      second_port_access <= 1'b1;
      wr(8'h45, 8'h0C);
      chk(eq_start_floor_p1, 4'hC);
      chk(eq_start_floor_p0, 4'h8);
      rd(8'h3B, 8'h15);
      rd(8'h44, 8'h60);
      @(posedge sys_clk);
      second_port_access <= 1'b0;
      wr(8'h44, 8'h60);
      chk(eq_adapt_off_p0, 1'b1);
      @(posedge sys_clk);
      port0_sel <= 1'b1;
      eq_floor_override <= 1'b1;
      cyc(3);
      chk(eq_floor_active, 1'b0);
      @(posedge sys_clk);
      eq_floor_apply <= 1'b1;
      cyc(3);
      chk(eq_floor_active, 1'b1);
      for (i = 0; i < 4; i++) begin
         wr(8'h52, {i[0], 7'h00});
         @(posedge sys_clk);
         loop_driver_enable <= i[1];
         cyc(2);
         repeat (4) begin
            p = i[0] ? secondary_input : primary_input;
            cyc(1);
            chk(loop_through_out, i[1] & p);
         end
      end
      end_sim;
   end
endmodule
